// file: hdl/xlat_window.sv
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module xlat_window (
  input wire logic clk,
  input wire logic resetn,
  // straps, sampled once after reset release; io_base_strap is decoded live
  input wire logic translator_master_enable_strap,
  input wire logic window_two_page_strap,
  input wire logic window_bit15_match_strap,
  input wire logic window_bit14_match_strap,
  input wire logic window_bit13_match_strap,
  input wire logic window_bit12_match_strap,
  input wire logic [5:0] io_base_strap,
  // processor side
  input wire logic cpu_addr_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic io_write,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  // system bus side
  output logic bus_addr_valid,
  output logic [23:0] bus_addr,
  output logic window_hit,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    logic strap_done; // straps taken
    logic cfg_en; // master enable
    logic cfg_two; // two-page window
    logic [3:0] cfg_match; // match for address 15..12
    logic out_valid; // bus address valid
    logic [23:0] out_addr; // translated address
    logic out_hit; // last address hit window
    logic out_page; // page used on last hit
    logic [15:0] hit_cnt; // window hits, wraps
    logic ack; // avalon answer cycle
    logic [31:0] rdata; // avalon read data
  } win_state_t;

  win_state_t st_r; // registered state
  win_state_t st_nxt; // next state

  logic [7:0] page0; // page 0 contents
  logic [7:0] page1; // page 1 contents
  logic io_sel; // i/o address in our four ports
  logic io_we0; // processor write to page 0
  logic io_we1; // processor write to page 1
  logic av_req; // avalon request pending
  logic sw_we0; // avalon write to page 0
  logic sw_we1; // avalon write to page 1
  logic hit; // current address in window
  logic sel_page; // current page select
  logic [7:0] sel_val; // selected page contents
  logic [3:0] strap_match; // strapped match value

  // ***********************************************************************
  // processor i/o port decode
  // ***********************************************************************
  // ports are write-only, reads are not decoded at all
  assign io_sel = io_write && (io_addr[7:2] == io_base_strap);
  assign io_we0 = io_sel && (io_addr[1:0] == xlat_pkg::IO_PAGE0_OFS);
  assign io_we1 = io_sel && (io_addr[1:0] == xlat_pkg::IO_PAGE1_OFS);

  // ***********************************************************************
  // avalon decode
  // ***********************************************************************
  // one wait cycle, then the answer; the ack gates the write
  assign av_req = avs_read || avs_write;
  assign avs_waitrequest = av_req && !st_r.ack;
  assign sw_we0 = avs_write && st_r.ack
    && (avs_address == xlat_pkg::PAGE0_OFS);
  assign sw_we1 = avs_write && st_r.ack
    && (avs_address == xlat_pkg::PAGE1_OFS);

  // page registers, one instance each
  xlat_page_reg u_page0 (
    .clk(clk),
    .resetn(resetn),
    .io_we(io_we0),
    .io_data(io_wdata),
    .sw_we(sw_we0),
    .sw_data(avs_writedata[7:0]),
    .page(page0)
  );

  xlat_page_reg u_page1 (
    .clk(clk),
    .resetn(resetn),
    .io_we(io_we1),
    .io_data(io_wdata),
    .sw_we(sw_we1),
    .sw_data(avs_writedata[7:0]),
    .page(page1)
  );

  // ***********************************************************************
  // window compare
  // ***********************************************************************
  assign strap_match = {window_bit15_match_strap, window_bit14_match_strap,
    window_bit13_match_strap, window_bit12_match_strap};

  // two-page mode compares only 15..13, giving an 8K boundary
  always_comb begin
    hit = 1'b0;
    sel_page = 1'b0;
    if (st_r.cfg_en && cpu_addr_valid) begin
      if (st_r.cfg_two) begin
        hit = (cpu_addr[15:13] == st_r.cfg_match[3:1]);
        sel_page = cpu_addr[12];
      end else begin
        hit = (cpu_addr[15:12] == st_r.cfg_match);
      end
    end
  end

  assign sel_val = sel_page ? page1 : page0;

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    st_nxt = st_r;
    // straps are static; take them on the first edge after release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.cfg_en = translator_master_enable_strap;
      st_nxt.cfg_two = window_two_page_strap;
      st_nxt.cfg_match = strap_match;
      if (window_two_page_strap) begin
        st_nxt.cfg_match[0] = 1'b0;
      end
    end
    // translated address, one cycle behind the processor address
    st_nxt.out_valid = cpu_addr_valid;
    st_nxt.out_hit = hit;
    if (hit) begin
      st_nxt.out_addr = {4'h0, sel_val, cpu_addr[11:0]};
      st_nxt.out_page = sel_page;
      st_nxt.hit_cnt = st_r.hit_cnt + 16'h0001;
    end else begin
      st_nxt.out_addr = {8'h00, cpu_addr};
    end
    // avalon answer
    st_nxt.ack = av_req && !st_r.ack;
    st_nxt.rdata = 32'h0000_0000;
    if (avs_read && !st_r.ack) begin
      case (avs_address)
        xlat_pkg::CFG_OFS: begin
          st_nxt.rdata[xlat_pkg::CFG_EN_BIT] = st_r.cfg_en;
          st_nxt.rdata[xlat_pkg::CFG_TWO_BIT] = st_r.cfg_two;
          st_nxt.rdata[xlat_pkg::CFG_MATCH_LSB +: 4] = st_r.cfg_match;
        end
        xlat_pkg::PAGE0_OFS: st_nxt.rdata[7:0] = page0;
        xlat_pkg::PAGE1_OFS: st_nxt.rdata[7:0] = page1;
        xlat_pkg::STATUS_OFS: begin
          st_nxt.rdata[xlat_pkg::ST_HIT_BIT] = st_r.out_hit;
          st_nxt.rdata[xlat_pkg::ST_PAGE_BIT] = st_r.out_page;
          st_nxt.rdata[xlat_pkg::ST_CNT_LSB +: 16] = st_r.hit_cnt;
        end
        default: st_nxt.rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    // software may override the strapped configuration
    if (avs_write && st_r.ack && avs_address == xlat_pkg::CFG_OFS) begin
      st_nxt.cfg_en = avs_writedata[xlat_pkg::CFG_EN_BIT];
      st_nxt.cfg_two = avs_writedata[xlat_pkg::CFG_TWO_BIT];
      st_nxt.cfg_match = avs_writedata[xlat_pkg::CFG_MATCH_LSB +: 4];
      if (avs_writedata[xlat_pkg::CFG_TWO_BIT]) begin
        st_nxt.cfg_match[0] = 1'b0;
      end
    end
  end

  // ***********************************************************************
  // registers
  // ***********************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{
        strap_done: 1'b0,
        cfg_en: xlat_pkg::STD_ENABLE,
        cfg_two: xlat_pkg::STD_TWO_PAGE,
        cfg_match: xlat_pkg::STD_MATCH,
        out_valid: 1'b0,
        out_addr: 24'h00_0000,
        out_hit: 1'b0,
        out_page: 1'b0,
        hit_cnt: 16'h0000,
        ack: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_addr_valid = st_r.out_valid;
  assign bus_addr = st_r.out_addr;
  assign window_hit = st_r.out_hit;
  assign avs_readdata = st_r.rdata;

  // ***********************************************************************
  // checks
  // ***********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  no_xlat_off_a: assert property (
    !st_r.cfg_en ##1 1'b1 |-> !window_hit && bus_addr == {8'h00, $past(cpu_addr)})
    else $error("relocation while translator disabled");
  two_page_lsb_a: assert property (
    st_r.cfg_two |-> !st_r.cfg_match[0])
    else $error("bit 12 match not zero in two-page mode");
  page_select_a: assert property (
    hit && st_r.cfg_two |=> bus_addr[19:12] ==
      ($past(cpu_addr[12]) ? $past(page1) : $past(page0)))
    else $error("wrong page register used");
  offset_keep_a: assert property (
    cpu_addr_valid |=> bus_addr[11:0] == $past(cpu_addr[11:0]))
    else $error("offset bits altered");
  hit_compare_a: assert property (
    st_r.cfg_en && cpu_addr_valid && !st_r.cfg_two
      && cpu_addr[15:12] == st_r.cfg_match |=> window_hit)
    else $error("window hit missed");
  single_bound_a: assert property (
    cpu_addr_valid && st_r.cfg_two
      && cpu_addr[15:13] != st_r.cfg_match[3:1] |=> !window_hit)
    else $error("hit outside 8K window");
  port_load_a: assert property (
    io_we1 |=> page1 == $past(io_wdata))
    else $error("page 1 port write lost");
  page_reset_a: assert property (
    $rose(resetn) |-> page0 == 8'h00 && page1 == 8'h00)
    else $error("page registers not cleared");
  config_mode_a: assert property (
    !st_r.strap_done && !(avs_write && st_r.ack)
      |=> st_r.cfg_two == $past(window_two_page_strap))
    else $error("size strap not taken");
  bus_answer_a: assert property (
    av_req && !st_r.ack |=> st_r.ack && !avs_waitrequest)
    else $error("avalon answer late");

  hit_page1_c: cover property (hit && st_r.cfg_two && sel_page);
  hit_single_c: cover property (hit && !st_r.cfg_two);
  io_load0_c: cover property (io_we0);
  av_read_c: cover property (avs_read && st_r.ack);
endmodule : xlat_window
`default_nettype wire

// file: hdl/xlat_pkg.sv
// ***********************************************************************
// shared constants of the address window translator
// ***********************************************************************
package xlat_pkg;
  // widths
  localparam int CPU_AW = 16;          // processor address width
  localparam int BUS_AW = 24;          // system bus address width
  localparam int PAGE_W = 8;           // page register width
  localparam int OFS_W = 12;           // offset inside one 4K page
  localparam int IO_AW = 8;            // processor i/o address width
  localparam int AV_AW = 4;            // avalon byte address width
  // processor i/o ports, offset from the strapped i/o base
  localparam logic [1:0] IO_PAGE0_OFS = 2'h2;
  localparam logic [1:0] IO_PAGE1_OFS = 2'h3;
  // avalon register byte offsets
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] PAGE0_OFS = 4'h4;
  localparam logic [3:0] PAGE1_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;
  // config register fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_TWO_BIT = 1;
  localparam int CFG_MATCH_LSB = 4;
  // status register fields
  localparam int ST_HIT_BIT = 0;
  localparam int ST_PAGE_BIT = 1;
  localparam int ST_CNT_LSB = 16;
  // reset values: window at a000, two pages, translator off
  localparam logic [3:0] STD_MATCH = 4'hA;
  localparam logic STD_TWO_PAGE = 1'b1;
  localparam logic STD_ENABLE = 1'b0;
  localparam logic [7:0] PAGE_RESET = 8'h00;
endpackage : xlat_pkg

// file: hdl/xlat_page_reg.sv
`timescale 1ns/10ps
`default_nettype none
// ***********************************************************************
// one relocation page register
// ***********************************************************************
module xlat_page_reg (
  input wire logic clk,
  input wire logic resetn,
  input wire logic io_we,
  input wire logic [7:0] io_data,
  input wire logic sw_we,
  input wire logic [7:0] sw_data,
  output logic [7:0] page
);
  // whole state of this register
  typedef struct packed {
    logic [7:0] page;
  } page_state_t;

  page_state_t st_r; // registered state
  page_state_t st_nxt; // next state

  // processor port write wins over a bus write in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (io_we) begin
      st_nxt.page = io_data;
    end else if (sw_we) begin
      st_nxt.page = sw_data;
    end
  end

  // cleared to the bottom 4K of memory on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{page: xlat_pkg::PAGE_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign page = st_r.page;
endmodule : xlat_page_reg
`default_nettype wire

// file: sim/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***********************************************************************
// processor core: memory addresses and port writes
// ***********************************************************************
module cpu_model (
  input wire logic clk,
  output logic cpu_addr_valid,
  output logic [15:0] cpu_addr,
  output logic io_write,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  // quiet bus at time zero
  initial begin
    cpu_addr_valid = 1'b0;
    cpu_addr = 16'h0000;
    io_write = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
  end
  // one out cycle; stale lines flip so no old value lingers
  task automatic io_out(input logic [7:0] a, input logic [7:0] d);
    io_write <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_write <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    @(posedge clk);
  endtask : io_out
  // software loads both pages through ports base+2 and base+3
  task automatic load_pages(input logic [7:0] b, input logic [7:0] p0,
                            input logic [7:0] p1);
    io_out(b + 8'h02, p0);
    io_out(b + 8'h03, p1);
  endtask : load_pages
  // one memory reference, held for a single edge
  task automatic mem(input logic [15:0] a);
    cpu_addr_valid <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_addr_valid <= 1'b0;
    cpu_addr <= ~a;
  endtask : mem
endmodule : cpu_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ***********************************************************************
  // signals
  // ***********************************************************************
  logic clk, resetn, en_s, two_s;
  logic [3:0] match_s, avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic cpu_addr_valid, io_write, bus_addr_valid, window_hit;
  logic [15:0] cpu_addr;
  logic [7:0] io_addr, io_wdata;
  logic [23:0] bus_addr;
  int err_total, comparisons;
  // one translation case: straps, address, expected result
  typedef struct packed {
    logic en; logic two; logic [3:0] m;
    logic [15:0] a; logic hit; logic [23:0] b;
  } row_t;
  row_t rows [10];
  cpu_model u_cpu (.clk(clk), .cpu_addr_valid(cpu_addr_valid),
    .cpu_addr(cpu_addr), .io_write(io_write), .io_addr(io_addr),
    .io_wdata(io_wdata));
  xlat_window dut (.clk(clk), .resetn(resetn),
    .translator_master_enable_strap(en_s), .window_two_page_strap(two_s),
    .window_bit15_match_strap(match_s[3]),
    .window_bit14_match_strap(match_s[2]),
    .window_bit13_match_strap(match_s[1]),
    .window_bit12_match_strap(match_s[0]), .io_base_strap(6'h38),
    .cpu_addr_valid(cpu_addr_valid), .cpu_addr(cpu_addr),
    .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
    .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr),
    .window_hit(window_hit), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ***********************************************************************
  // tasks
  // ***********************************************************************
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // register value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // translated address compare, valid must follow the request
  task automatic chk_bus(input logic hit, input logic [23:0] b);
    comparisons++;
    if ({bus_addr_valid, window_hit, bus_addr} !== {1'b1, hit, b}) begin
      err_total++;
      $display("ERROR %0t bus got %h exp %h", $time, bus_addr, b);
    end
  endtask : chk_bus
  // straps settle while reset is low, captured after release
  task automatic do_reset(input logic e, input logic t,
                          input logic [3:0] m);
    en_s <= e;
    two_s <= t;
    match_s <= m;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  // avalon cycle; bounded wait so a stuck slave ends the run
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      results();
    end
    @(posedge clk);
  endtask : av
  // one address in, result one edge later
  task automatic xl(input logic [15:0] a, input logic hit,
                    input logic [23:0] b);
    u_cpu.mem(a);
    @(posedge clk);
    chk_bus(hit, b);
  endtask : xl
  // ***********************************************************************
  // main sequence
  // ***********************************************************************
  initial begin
    err_total = 0;
    comparisons = 0;
    resetn = 1'b0;
    {en_s, two_s, match_s} = 6'h0A;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    // pages loaded with 05 and 3c before each case
    rows = '{'{1'b1, 1'b1, 4'hA, 16'hA123, 1'b1, 24'h00_5123},
             '{1'b1, 1'b1, 4'hA, 16'hBFFF, 1'b1, 24'h03_CFFF},
             '{1'b1, 1'b1, 4'hA, 16'hC000, 1'b0, 24'h00_C000},
             '{1'b0, 1'b1, 4'hA, 16'hA123, 1'b0, 24'h00_A123},
             '{1'b1, 1'b0, 4'hA, 16'hA123, 1'b1, 24'h00_5123},
             '{1'b1, 1'b0, 4'hA, 16'hB123, 1'b0, 24'h00_B123},
             '{1'b1, 1'b0, 4'hB, 16'hB456, 1'b1, 24'h00_5456},
             '{1'b1, 1'b0, 4'h5, 16'h5000, 1'b1, 24'h00_5000},
             '{1'b1, 1'b1, 4'hB, 16'hB010, 1'b1, 24'h03_C010},
             '{1'b0, 1'b0, 4'h5, 16'h5000, 1'b0, 24'h00_5000}};
    @(posedge clk);
    foreach (rows[i]) begin
      do_reset(rows[i].en, rows[i].two, rows[i].m);
      u_cpu.load_pages(8'hE0, 8'h05, 8'h3C);
      xl(rows[i].a, rows[i].hit, rows[i].b);
    end
    // shipped straps: pages cleared, window a000, unit off
    do_reset(1'b0, 1'b1, 4'hA);
    av(1'b0, xlat_pkg::PAGE0_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b0, xlat_pkg::PAGE1_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b0, xlat_pkg::CFG_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_00A2);
    xl(16'hA123, 1'b0, 24'h00_A123);
    av(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // only base+2 and base+3 under the strapped base load pages
    u_cpu.io_out(8'hE0, 8'h11);
    u_cpu.io_out(8'hE1, 8'h22);
    u_cpu.io_out(8'hD2, 8'h33);
    u_cpu.io_out(8'hE3, 8'h44);
    av(1'b0, xlat_pkg::PAGE0_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b0, xlat_pkg::PAGE1_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0044);
    u_cpu.io_out(8'hE2, 8'h55);
    // software side: page 1 and enable written over avalon
    av(1'b1, xlat_pkg::PAGE1_OFS, 32'h0000_0077);
    av(1'b1, xlat_pkg::CFG_OFS, 32'h0000_00A3);
    xl(16'hB001, 1'b1, 24'h07_7001);
    // status: no hit now, last hit used page 1, one hit since reset
    av(1'b0, xlat_pkg::STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0001_0002);
    xl(16'hA001, 1'b1, 24'h05_5001);
    results();
  end
endmodule : tb
`default_nettype wire
